// ===== common/lbl_pkg.sv
// constants and types for the line-sequential colour select block
package lbl_pkg;

  // register byte offsets
  localparam logic [7:0] LBL_OFS_CTRL = 8'h00;
  localparam logic [7:0] LBL_OFS_SOFT_RST = 8'h04;
  localparam logic [7:0] LBL_OFS_CYC_RST = 8'h08;
  localparam logic [7:0] LBL_OFS_STATUS = 8'h0C;
  localparam logic [7:0] LBL_OFS_BASE = 8'h10;

  // control register field positions
  localparam int LBL_BIT_LINE_MODE = 0;
  localparam int LBL_BIT_PIN_FUNC = 1;
  localparam int LBL_BIT_FORCE_MUX = 2;
  localparam int LBL_BIT_INT_CLAMP = 3;
  localparam int LBL_POS_INT_COL = 4;
  localparam int LBL_POS_FORCED_COL = 6;

  // reset values
  localparam logic [7:0] LBL_CTRL_RST = 8'h40;
  localparam logic [7:0] LBL_BASE_RST = 8'h00;

  // colour codes of the counter and mux selects
  localparam logic [1:0] LBL_COL_RED = 2'h0;
  localparam logic [1:0] LBL_COL_GREEN = 2'h1;
  localparam logic [1:0] LBL_COL_BLUE = 2'h2;

  // auto-cycle counter states
  typedef enum logic [1:0] {
    CYC_RED,
    CYC_GREEN,
    CYC_BLUE
  } lbl_cyc_e;

  // fields of the line mode control register
  typedef struct packed {
    logic [1:0] forced_colour_sel;
    logic [1:0] internal_colour_sel;
    logic internal_clamp_enable;
    logic force_mux_enable;
    logic pin_function_choice;
    logic line_sequential_mode;
  } lbl_ctrl_s;

  // settings from the other setup registers, kept locally
  typedef struct packed {
    logic [1:0] mono_channel_pick;
    logic single_channel_select;
  } lbl_base_s;

  // effective controls handed to the analogue path
  typedef struct packed {
    logic single_channel_eff;
    logic [1:0] channel_pick_eff;
    logic green_pga_en;
    logic blue_pga_en;
    logic [1:0] input_mux_sel;
    logic [1:0] gain_offset_mux_sel;
    logic clamp_strobe;
  } lbl_out_s;

endpackage

// ===== design/lbl_select.sv
// line-sequential colour select control with apb register access
//
// Our own choices: the register offsets and the APB slave port.
module lbl_select (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clamp_or_cycle_pin,
  output lbl_pkg::lbl_out_s ctrl_out
);

  lbl_pkg::lbl_ctrl_s ctrl_r;
  lbl_pkg::lbl_base_s base_r;
  lbl_pkg::lbl_cyc_e cyc_r;
  lbl_pkg::lbl_cyc_e cyc_nxt;
  lbl_pkg::lbl_out_s out_nxt;
  lbl_pkg::lbl_out_s out_r;

  logic [31:0] prdata_r;
  logic [31:0] rdata_nxt;
  logic pready_r;
  logic pslverr_r;
  logic mapped;
  logic setup_ph;
  logic wr_acc;
  logic soft_rst;
  logic cyc_rst;

  logic pin_s1_r;
  logic pin_s2_r;
  logic pin_d_r;
  logic pin_rise;
  logic auto_cycle;

  // address decode
  always_comb begin
    case (paddr)
      lbl_pkg::LBL_OFS_CTRL,
      lbl_pkg::LBL_OFS_SOFT_RST,
      lbl_pkg::LBL_OFS_CYC_RST,
      lbl_pkg::LBL_OFS_STATUS,
      lbl_pkg::LBL_OFS_BASE: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // bus phase qualifiers
  assign setup_ph = psel && !penable;
  // writes land at the access edge only
  assign wr_acc = psel && penable && pready_r && pwrite && mapped;
  assign soft_rst = wr_acc && (paddr == lbl_pkg::LBL_OFS_SOFT_RST);
  assign cyc_rst = wr_acc && (paddr == lbl_pkg::LBL_OFS_CYC_RST);

  // read data mux, prepared in the setup phase
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (paddr)
      lbl_pkg::LBL_OFS_CTRL: begin
        rdata_nxt[7:0] = ctrl_r;
      end
      lbl_pkg::LBL_OFS_BASE: begin
        rdata_nxt[2:0] = base_r;
      end
      lbl_pkg::LBL_OFS_STATUS: begin
        rdata_nxt[1:0] = cyc_r;
        rdata_nxt[11:2] = out_r;
      end
      default: begin
        rdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  // one-cycle access: ready rises for the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setup_ph;
    end
  end

  // read data and error latched at the setup edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rdata_nxt;
      pslverr_r <= !mapped;
    end else if (pready_r) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // control register, defaults on either reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= lbl_pkg::LBL_CTRL_RST;
    end else if (soft_rst) begin
      ctrl_r <= lbl_pkg::LBL_CTRL_RST;
    end else if (wr_acc && (paddr == lbl_pkg::LBL_OFS_CTRL)) begin
      ctrl_r <= pwdata[7:0];
    end
  end

  // base settings from the other setup registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_r <= lbl_pkg::LBL_BASE_RST[2:0];
    end else if (soft_rst) begin
      base_r <= lbl_pkg::LBL_BASE_RST[2:0];
    end else if (wr_acc && (paddr == lbl_pkg::LBL_OFS_BASE)) begin
      base_r <= pwdata[2:0];
    end
  end

  // two-flop synchroniser, then a third flop for edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_d_r <= 1'b0;
    end else begin
      pin_s1_r <= clamp_or_cycle_pin;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  // edge taken from synchronised stages only
  assign pin_rise = pin_s2_r && !pin_d_r;

  // auto-cycling needs line mode and pin function
  assign auto_cycle = ctrl_r.line_sequential_mode && ctrl_r.pin_function_choice;

  // red, green, blue, back to red
  always_comb begin
    case (cyc_r)
      lbl_pkg::CYC_RED: begin
        cyc_nxt = lbl_pkg::CYC_GREEN;
      end
      lbl_pkg::CYC_GREEN: begin
        cyc_nxt = lbl_pkg::CYC_BLUE;
      end
      lbl_pkg::CYC_BLUE: begin
        cyc_nxt = lbl_pkg::CYC_RED;
      end
      default: begin
        cyc_nxt = lbl_pkg::CYC_RED;
      end
    endcase
  end

  // counter; a software reset write beats a same-cycle pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_r <= lbl_pkg::CYC_RED;
    end else if (cyc_rst || soft_rst) begin
      cyc_r <= lbl_pkg::CYC_RED;
    end else if (auto_cycle && pin_rise) begin
      cyc_r <= cyc_nxt;
    end
  end

  // effective controls for the analogue path
  always_comb begin
    out_nxt.single_channel_eff = base_r.single_channel_select;
    out_nxt.channel_pick_eff = base_r.mono_channel_pick;
    out_nxt.green_pga_en = 1'b1;
    out_nxt.blue_pga_en = 1'b1;
    out_nxt.input_mux_sel = base_r.mono_channel_pick;
    out_nxt.gain_offset_mux_sel = base_r.mono_channel_pick;
    // outside line mode the pin is the clamp strobe
    out_nxt.clamp_strobe = pin_s2_r;
    if (ctrl_r.line_sequential_mode) begin
      out_nxt.single_channel_eff = 1'b1;
      out_nxt.channel_pick_eff = lbl_pkg::LBL_COL_RED;
      out_nxt.green_pga_en = 1'b0;
      out_nxt.blue_pga_en = 1'b0;
      if (ctrl_r.pin_function_choice) begin
        out_nxt.input_mux_sel = cyc_r;
        out_nxt.gain_offset_mux_sel = cyc_r;
        out_nxt.clamp_strobe = ctrl_r.internal_clamp_enable;
      end else begin
        out_nxt.input_mux_sel = ctrl_r.internal_colour_sel;
        out_nxt.gain_offset_mux_sel = ctrl_r.internal_colour_sel;
        out_nxt.clamp_strobe = pin_s2_r;
      end
      if (ctrl_r.force_mux_enable) begin
        out_nxt.input_mux_sel = ctrl_r.forced_colour_sel;
      end
    end
  end

  // registered outputs; the clamp strobe is three cycles behind the pin, the cycled mux selects four
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= '0;
    end else begin
      out_r <= out_nxt;
    end
  end

  assign ctrl_out = out_r;

endmodule

// ===== tb/lbl_pin_model.sv
// scanner controller model driving the clamp or cycle pin
module lbl_pin_model (
  input wire logic pclk,
  input wire logic go,
  input wire logic lvl,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] hold_r = 2'h0;
  // pulse held three clocks so the two-flop sync cannot miss it
  always @(posedge pclk) begin
    if (go) hold_r <= 2'h3;
    else if (hold_r != 2'h0) hold_r <= hold_r - 2'h1;
  end
  // static clamp level, or'ed with cycle pulses
  assign pin = lvl | (hold_r != 2'h0);
endmodule

// ===== tb/lbl_select_chk.sv
// assertion checker for the colour select block
module lbl_select_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic clamp_or_cycle_pin,
  input wire lbl_pkg::lbl_out_s ctrl_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctl_r, prv_r;
  logic [1:0] age_r;
  logic [3:0] pin_r;
  logic wr, stab;
  assign wr = psel && penable && pready && pwrite;
  assign stab = age_r == 2'h3 && ctl_r == prv_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow control word; age and prv keep checks off transients
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= lbl_pkg::LBL_CTRL_RST;
      prv_r <= lbl_pkg::LBL_CTRL_RST;
      age_r <= 2'h0;
      pin_r <= 4'h0;
    end else begin
      prv_r <= ctl_r;
      pin_r <= {pin_r[2:0], clamp_or_cycle_pin};
      if (age_r != 2'h3) age_r <= age_r + 2'h1;
      if (wr && paddr == 8'h00) ctl_r <= pwdata[7:0];
      if (wr && paddr == 8'h04) ctl_r <= lbl_pkg::LBL_CTRL_RST;
    end
  end
  line_force_a: assert property (stab && ctl_r[0] |->
    ctrl_out.single_channel_eff && ctrl_out.channel_pick_eff == 2'h0) else $error("no force");
  pga_gate_a: assert property (stab |-> ctrl_out.green_pga_en == !ctl_r[0]
    && ctrl_out.blue_pga_en == !ctl_r[0]) else $error("pga gating");
  force_mux_a: assert property (stab && ctl_r[0] && ctl_r[2] |->
    ctrl_out.input_mux_sel == ctl_r[7:6]) else $error("forced mux");
  int_mux_a: assert property (stab && ctl_r[1:0] == 2'h1 |->
    ctrl_out.gain_offset_mux_sel == ctl_r[5:4]) else $error("internal mux");
  auto_clamp_a: assert property (stab && ctl_r[1:0] == 2'h3 |->
    ctrl_out.clamp_strobe == ctl_r[3]) else $error("auto clamp");
  pin_clamp_a: assert property (stab && ctl_r[1:0] == 2'h1 &&
    pin_r == {4{clamp_or_cycle_pin}} |-> ctrl_out.clamp_strobe == clamp_or_cycle_pin)
    else $error("pin clamp");
  cyc_step_a: assert property (stab && $past(stab) && ctl_r[1:0] == 2'h3 &&
    $changed(ctrl_out.gain_offset_mux_sel) && ctrl_out.gain_offset_mux_sel != 2'h0
    |-> ctrl_out.gain_offset_mux_sel == $past(ctrl_out.gain_offset_mux_sel) + 2'h1)
    else $error("cycle order");
  bus_err_a: assert property (pready |->
    pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10})) else $error("slverr");
  rd_ctrl_a: assert property (pready && !pwrite && paddr == 8'h00 |->
    prdata == {24'h0, ctl_r}) else $error("ctrl readback");
  zero_wait_a: assert property (psel && !penable |=> pready) else $error("wait state");
  cover property (stab && ctl_r[1:0] == 2'h3 && $changed(ctrl_out.gain_offset_mux_sel));
  cover property (stab && ctl_r[1:0] == 2'h1 && ctrl_out.clamp_strobe);
  cover property (pready && pslverr);
endmodule
bind lbl_select lbl_select_chk u_lbl_select_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .clamp_or_cycle_pin(clamp_or_cycle_pin), .ctrl_out(ctrl_out));

// ===== tb/test_lbl_select.sv
// testbench for the colour select block
module test_lbl_select;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pin, go, lvl;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  lbl_pkg::lbl_out_s co;
  int err_total = 0;
  int n_compared = 0;
  lbl_select u_lbl_select (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clamp_or_cycle_pin(pin), .ctrl_out(co));
  lbl_pin_model u_lbl_pin_model (.pclk(pclk), .go(go), .lvl(lvl), .pin(pin));
  task automatic close_out;
    $display("compares %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next call never reassigns psel in this time step
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(a, 1'b1, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    xfer(a, 1'b0, 32'h0, q, e);
    cmp(q, x);
    cmp({31'h0, e}, {31'h0, xe});
  endtask
  // one cycle pulse request, then time for sync and low phase
  task automatic pulse;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    tick(8);
  endtask
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // watchdog, far beyond the roughly 130 cycles of the sequence
  initial begin
    tick(5000);
    err_total++;
    close_out();
  end
  // ctrl_out layout: single, channel_pick_eff[2], green, blue, in[2], gain[2], clamp
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    go = 1'b0;
    lvl = 1'b0;
    tick(5);
    presetn <= 1'b1;
    wr(8'h04, 32'h0);
    rd(8'h00, 32'h40, 1'b0);
    rd(8'h10, 32'h0, 1'b0);
    cmp(32'(co), 32'h060);
    wr(8'h10, 32'h2);
    wr(8'h00, 32'h84);
    tick(3);
    cmp(32'(co), 32'h0EA);
    wr(8'h00, 32'h65);
    rd(8'h00, 32'h65, 1'b0);
    tick(3);
    cmp(32'(co), 32'h20C);
    wr(8'h00, 32'h01);
    lvl <= 1'b1;
    tick(6);
    cmp(32'(co), 32'h201);
    wr(8'h00, 32'h0B);
    wr(8'h08, 32'h0);
    tick(3);
    cmp(32'(co), 32'h201);
    wr(8'h00, 32'h03);
    tick(3);
    cmp(32'(co), 32'h200);
    lvl <= 1'b0;
    tick(6);
    for (int i = 1; i <= 4; i++) begin
      pulse();
      cmp(32'(co), 32'h200 | (32'(i % 3) * 32'h0A));
    end
    wr(8'h00, 32'h01);
    pulse();
    rd(8'h0C, 32'h801, 1'b0);
    wr(8'h08, 32'h0);
    rd(8'h0C, 32'h800, 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    wr(8'h04, 32'h0);
    rd(8'h00, 32'h40, 1'b0);
    tick(3);
    cmp(32'(co), 32'h060);
    close_out();
  end
endmodule
